// [hw/apcr_pkg.sv]
// Constants, types and field layouts for the audio path configuration registers
// Overview of operation
// [R1] First mixer select zero routes line input
// [R2] First mixer mode: select, source, or off
// [R3] Filter source: first mixer or storage array
// [R4] Lowpass powerdown bit zero powers filter up
// [R5] Rate select: 8.0, 6.4, 5.3 kHz
// [R6] Second mixer mode can pass filter only
// [R7] Gain amplifier powerdown zero powers it up
// [R8] Input source zero selects gain amplifier
// [R9] Volume source code selects second mixer
// [R10] Volume powerdown zero powers attenuator up
// [R11] Three bit attenuation code, 011 is -12 dB
// [R12] Output select: volume or line input
// [R13] Stage mode 01: speaker high gain, aux off
// [R14] Host writes both when first register changes
// [R15] Cueing steps 512 times faster than playback
// [R16] Cueing stops at end marker, points next
// [R17] Aux gain 0 to 9 dB, 3 dB steps
// [R18] Line gain 6 to 15 dB, 3 dB steps
// [R19] Host writes first register before second
// [R20] Both registers take effect together on SCL rise
// [R21] Line out select zero picks mic feed-through
// [R22] Register updates only after full 16 bits
package apcr_pkg;

   // Serial port framing; address and command codes are arbitrary choices
   localparam logic [7:0] SLAVE_ADDR_W = 8'h80;
   localparam logic [7:0] CMD_LOAD_BOTH = 8'h8C;
   localparam logic [7:0] CMD_LOAD_SECOND = 8'h8D;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [1:0] IDX_FIRST_LO = 2'h1;
   localparam logic [1:0] IDX_SECOND_HI = 2'h2;
   localparam logic [1:0] IDX_SECOND_LO = 2'h3;

   // Reset values: everything zero
   localparam logic [15:0] FIRST_CFG_RESET = 16'h0000;
   localparam logic [15:0] SECOND_CFG_RESET = 16'h0000;

   // Field codes
   localparam logic [1:0] FMS_LINE_IN = 2'h0;
   localparam logic [1:0] FMM_SELECT_ONLY = 2'h1;
   localparam logic [1:0] FMM_SOURCE_ONLY = 2'h2;
   localparam logic [1:0] FMM_OFF = 2'h3;
   localparam logic [1:0] SMM_FILTER_ONLY = 2'h2;
   localparam logic [1:0] VSS_SECOND_MIXER = 2'h1;
   localparam logic [1:0] OUT_SEL_VOLUME = 2'h0;
   localparam logic [1:0] OUT_SEL_LINE_IN = 2'h1;
   localparam logic [1:0] OSM_SPEAKER_HIGH = 2'h1;
   localparam logic [2:0] LOS_MIC_THRU = 3'h0;
   localparam logic [3:0] AUX_GAIN_MIN_DB = 4'h0;
   localparam logic [3:0] LINE_GAIN_MIN_DB = 4'h6;
   localparam logic [3:0] GAIN_STEP_DB = 4'h3;

   // Playback step timing: one address step per sample
   localparam int SAMPLE_8K0_NS = 125000;
   localparam int SAMPLE_6K4_NS = 156250;
   localparam int SAMPLE_5K3_NS = 188679;
   localparam int CLK_PERIOD_NS = 10;
   localparam int STEP_8K0_CYC = SAMPLE_8K0_NS / CLK_PERIOD_NS;
   localparam int STEP_6K4_CYC = SAMPLE_6K4_NS / CLK_PERIOD_NS;
   localparam int STEP_5K3_CYC = SAMPLE_5K3_NS / CLK_PERIOD_NS;
   localparam int CUE_SPEEDUP = 512;
   localparam int ADDR_W = 16;

   typedef enum logic [1:0] {
      APCR_RATE_8K0 = 2'b00,
      APCR_RATE_6K4 = 2'b01,
      APCR_RATE_5K3 = 2'b10,
      APCR_RATE_RSVD = 2'b11
   } apcr_rate_t;

   typedef struct packed {
      logic [1:0] line_in_gain;
      logic line_in_powerdown;
      logic [1:0] aux_gain;
      logic aux_powerdown;
      logic input_source_select;
      logic [2:0] line_out_select;
      logic line_out_powerdown;
      logic [1:0] output_select;
      logic [1:0] output_stage_mode;
      logic volume_powerdown;
   } apcr_first_cfg_t;

   typedef struct packed {
      logic [1:0] volume_source_select;
      logic [2:0] attenuation_code;
      logic [1:0] first_mixer_select;
      logic [1:0] first_mixer_mode;
      logic [1:0] second_mixer_mode;
      logic filter_source_select;
      logic [1:0] rate_select;
      logic lowpass_powerdown;
      logic gain_amp_powerdown;
   } apcr_second_cfg_t;

   typedef struct packed {
      logic first_mixer_from_line_in;
      logic first_mixer_pass_select;
      logic first_mixer_pass_source;
      logic first_mixer_on;
      logic filter_from_array;
      logic lowpass_on;
      apcr_rate_t sample_rate;
      logic second_mixer_filter_only;
      logic gain_amp_on;
      logic input_from_gain_amp;
      logic volume_from_second_mixer;
      logic volume_on;
      logic [2:0] attenuation_code;
      logic output_from_volume;
      logic output_from_line_in;
      logic speaker_high_gain;
      logic aux_out_on;
      logic line_out_from_mic;
      logic line_out_on;
      logic [3:0] aux_gain_db;
      logic [3:0] line_in_gain_db;
   } apcr_path_ctrl_t;

endpackage : apcr_pkg

// [hw/apcr_regs.sv]
// Audio path configuration registers, serial register load and message cueing
`timescale 1ns/100ps
module apcr_regs #(
   parameter int STEP_8K0 = apcr_pkg::STEP_8K0_CYC,
   parameter int STEP_6K4 = apcr_pkg::STEP_6K4_CYC,
   parameter int STEP_5K3 = apcr_pkg::STEP_5K3_CYC
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   input wire logic playback_i,
   input wire logic cue_start_i,
   input wire logic message_end_marker_i,
   output apcr_pkg::apcr_first_cfg_t first_cfg_o,
   output apcr_pkg::apcr_second_cfg_t second_cfg_o,
   output apcr_pkg::apcr_path_ctrl_t path_ctrl_o,
   output logic [apcr_pkg::ADDR_W-1:0] message_addr_o,
   output logic cueing_o
);

   typedef enum logic [1:0] {
      APCR_PH_ADDR = 2'b00,
      APCR_PH_CMD = 2'b01,
      APCR_PH_DATA = 2'b10,
      APCR_PH_IGNORE = 2'b11
   } apcr_phase_t;

   typedef enum logic [1:0] {
      APCR_PL_IDLE = 2'b00,
      APCR_PL_PLAY = 2'b01,
      APCR_PL_CUE = 2'b10
   } apcr_play_t;

   logic [2:0] scl_sync_q;
   logic [2:0] sda_sync_q;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   apcr_phase_t phase_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] shift_q;
   logic [7:0] byte_in;
   logic [1:0] idx_q;
   logic ack_q;
   logic [7:0] hold_hi_q;
   logic [15:0] stage_first_q;
   logic stage_valid_q;
   logic both_cmd_q;
   apcr_pkg::apcr_first_cfg_t first_q;
   apcr_pkg::apcr_second_cfg_t second_q;
   apcr_play_t play_q;
   logic [14:0] step_cnt_q;
   logic [14:0] step_limit;
   logic step_due;
   logic [apcr_pkg::ADDR_W-1:0] addr_q;

   // Two-flop synchronisers plus one history flop for edge finding
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         scl_sync_q <= 3'h7;
         sda_sync_q <= 3'h7;
      end else begin
         scl_sync_q <= {scl_sync_q[1:0], scl_i};
         sda_sync_q <= {sda_sync_q[1:0], sda_i};
      end
   end

   // Edges use only the settled stages, never the first flop
   assign scl_rise = scl_sync_q[1] & ~scl_sync_q[2];
   assign scl_fall = ~scl_sync_q[1] & scl_sync_q[2];
   assign start_seen = scl_sync_q[1] & scl_sync_q[2] & ~sda_sync_q[1] & sda_sync_q[2];
   assign stop_seen = scl_sync_q[1] & scl_sync_q[2] & sda_sync_q[1] & ~sda_sync_q[2];
   assign byte_in = {shift_q[6:0], sda_sync_q[1]};

   // Bit counter and shifter; bits are sampled on SCL rise, MSB first
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         bit_cnt_q <= 4'h0;
         shift_q <= 8'h00;
      end else if (start_seen || stop_seen) begin
         bit_cnt_q <= 4'h0;
      end else if (scl_rise) begin
         shift_q <= byte_in;
         bit_cnt_q <= (bit_cnt_q == apcr_pkg::BIT_ACK) ? 4'h0 : bit_cnt_q + 4'h1;
      end
   end

   // Transfer phase; each byte is judged on the rise of its eighth bit
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         phase_q <= APCR_PH_IGNORE;
         idx_q <= 2'h0;
         ack_q <= 1'b0;
         both_cmd_q <= 1'b0;
      end else if (start_seen) begin
         phase_q <= APCR_PH_ADDR;
         idx_q <= 2'h0;
         ack_q <= 1'b0;
         both_cmd_q <= 1'b0;
      end else if (stop_seen) begin
         phase_q <= APCR_PH_IGNORE;
         ack_q <= 1'b0;
      end else if (scl_rise && bit_cnt_q == apcr_pkg::BIT_LAST) begin
         unique case (phase_q)
            APCR_PH_ADDR: begin
               ack_q <= (byte_in == apcr_pkg::SLAVE_ADDR_W);
               phase_q <= (byte_in == apcr_pkg::SLAVE_ADDR_W) ? APCR_PH_CMD : APCR_PH_IGNORE;
            end
            APCR_PH_CMD: begin
               if (byte_in == apcr_pkg::CMD_LOAD_BOTH) begin
                  ack_q <= 1'b1;
                  both_cmd_q <= 1'b1;
                  idx_q <= 2'h0;
                  phase_q <= APCR_PH_DATA;
               end else if (byte_in == apcr_pkg::CMD_LOAD_SECOND) begin
                  ack_q <= 1'b1;
                  idx_q <= apcr_pkg::IDX_SECOND_HI;
                  phase_q <= APCR_PH_DATA;
               end else begin
                  ack_q <= 1'b0;
                  phase_q <= APCR_PH_IGNORE;
               end
            end
            APCR_PH_DATA: begin
               ack_q <= 1'b1;
               idx_q <= idx_q + 2'h1;
               // Bytes past the second register are refused
               if (idx_q == apcr_pkg::IDX_SECOND_LO) begin
                  phase_q <= APCR_PH_IGNORE;
               end
            end
            APCR_PH_IGNORE: begin
               ack_q <= 1'b0;
            end
         endcase
      end
   end

   // Open-drain acknowledge: pull low through the ninth clock
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         sda_oe_n_o <= 1'b1;
         sda_o <= 1'b0;
      end else if (start_seen || stop_seen) begin
         sda_oe_n_o <= 1'b1;
      end else if (scl_fall) begin
         sda_oe_n_o <= ~(ack_q && bit_cnt_q == apcr_pkg::BIT_ACK);
      end
   end

   // Staging of incoming bytes; nothing reaches the path until a word is whole
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         hold_hi_q <= 8'h00;
         stage_first_q <= apcr_pkg::FIRST_CFG_RESET;
         stage_valid_q <= 1'b0;
      end else if (start_seen) begin
         stage_valid_q <= 1'b0;
      end else if (scl_rise && bit_cnt_q == apcr_pkg::BIT_LAST && phase_q == APCR_PH_DATA) begin
         if (idx_q == apcr_pkg::IDX_FIRST_LO) begin
            stage_first_q <= {hold_hi_q, byte_in}; // [R22]
            stage_valid_q <= both_cmd_q; // [R19]
         end else begin
            hold_hi_q <= byte_in;
         end
      end
   end

   // Commit on the SCL rise that completes the second register; a staged first
   // register goes live on the same edge so both settings change together
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         first_q <= apcr_pkg::FIRST_CFG_RESET;
         second_q <= apcr_pkg::SECOND_CFG_RESET;
      end else if (scl_rise && bit_cnt_q == apcr_pkg::BIT_LAST && phase_q == APCR_PH_DATA
                   && idx_q == apcr_pkg::IDX_SECOND_LO) begin
         second_q <= {hold_hi_q, byte_in}; // [R20] [R22]
         if (stage_valid_q) begin
            first_q <= stage_first_q; // [R14] [R20]
         end
      end
   end

   // Registered path decode feeding the analogue switches and power controls
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         path_ctrl_o <= '0;
      end else begin
         path_ctrl_o.first_mixer_from_line_in <=
            (second_q.first_mixer_select == apcr_pkg::FMS_LINE_IN); // [R1]
         path_ctrl_o.first_mixer_pass_select <=
            (second_q.first_mixer_mode == apcr_pkg::FMM_SELECT_ONLY); // [R2]
         path_ctrl_o.first_mixer_pass_source <=
            (second_q.first_mixer_mode == apcr_pkg::FMM_SOURCE_ONLY); // [R2]
         path_ctrl_o.first_mixer_on <= (second_q.first_mixer_mode != apcr_pkg::FMM_OFF); // [R2]
         path_ctrl_o.filter_from_array <= second_q.filter_source_select; // [R3]
         path_ctrl_o.lowpass_on <= ~second_q.lowpass_powerdown; // [R4]
         path_ctrl_o.sample_rate <= apcr_pkg::apcr_rate_t'(second_q.rate_select); // [R5]
         path_ctrl_o.second_mixer_filter_only <=
            (second_q.second_mixer_mode == apcr_pkg::SMM_FILTER_ONLY); // [R6]
         path_ctrl_o.gain_amp_on <= ~second_q.gain_amp_powerdown; // [R7]
         path_ctrl_o.input_from_gain_amp <= ~first_q.input_source_select; // [R8]
         path_ctrl_o.volume_from_second_mixer <=
            (second_q.volume_source_select == apcr_pkg::VSS_SECOND_MIXER); // [R9]
         path_ctrl_o.volume_on <= ~first_q.volume_powerdown; // [R10]
         path_ctrl_o.attenuation_code <= second_q.attenuation_code; // [R11]
         path_ctrl_o.output_from_volume <=
            (first_q.output_select == apcr_pkg::OUT_SEL_VOLUME); // [R12]
         path_ctrl_o.output_from_line_in <=
            (first_q.output_select == apcr_pkg::OUT_SEL_LINE_IN); // [R12]
         path_ctrl_o.speaker_high_gain <=
            (first_q.output_stage_mode == apcr_pkg::OSM_SPEAKER_HIGH); // [R13]
         path_ctrl_o.aux_out_on <=
            (first_q.output_stage_mode != apcr_pkg::OSM_SPEAKER_HIGH); // [R13]
         path_ctrl_o.line_out_from_mic <=
            (first_q.line_out_select == apcr_pkg::LOS_MIC_THRU); // [R21]
         path_ctrl_o.line_out_on <= ~first_q.line_out_powerdown; // [R21]
         path_ctrl_o.aux_gain_db <= apcr_pkg::AUX_GAIN_MIN_DB
            + 4'(first_q.aux_gain * apcr_pkg::GAIN_STEP_DB); // [R17]
         path_ctrl_o.line_in_gain_db <= apcr_pkg::LINE_GAIN_MIN_DB
            + 4'(first_q.line_in_gain * apcr_pkg::GAIN_STEP_DB); // [R18]
      end
   end

   assign first_cfg_o = first_q;
   assign second_cfg_o = second_q;

   // Step period follows the selected sample rate; cueing divides it by 512.
   // The reserved rate code falls back to the 8.0 kHz timing.
   always_comb begin
      unique case (second_q.rate_select)
         2'b01: step_limit = 15'(STEP_6K4);
         2'b10: step_limit = 15'(STEP_5K3);
         default: step_limit = 15'(STEP_8K0);
      endcase
      if (play_q == APCR_PL_CUE) begin
         step_limit = 15'(step_limit / 15'(apcr_pkg::CUE_SPEEDUP)); // [R15]
      end
   end

   assign step_due = (step_cnt_q >= step_limit - 15'h1);

   // Step timer; restarts on every mode change so a step never comes early
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         step_cnt_q <= 15'h0;
      end else if (play_q == APCR_PL_IDLE || cue_start_i || step_due) begin
         step_cnt_q <= 15'h0;
      end else begin
         step_cnt_q <= step_cnt_q + 15'h1;
      end
   end

   // Playback and cueing sequencer
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         play_q <= APCR_PL_IDLE;
      end else begin
         unique case (play_q)
            APCR_PL_IDLE: begin
               if (playback_i) begin
                  play_q <= APCR_PL_PLAY;
               end
            end
            APCR_PL_PLAY: begin
               if (!playback_i) begin
                  play_q <= APCR_PL_IDLE;
               end else if (cue_start_i) begin
                  play_q <= APCR_PL_CUE;
               end
            end
            APCR_PL_CUE: begin
               // Cueing halts at the marker; with playback still requested, idle goes back to playback on the next cycle
               if (!playback_i || (step_due && message_end_marker_i)) begin
                  play_q <= APCR_PL_IDLE; // [R16]
               end
            end
            default: play_q <= APCR_PL_IDLE;
         endcase
      end
   end

   // Message address: one step per period, also past the marker that ends a cue
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         addr_q <= '0;
      end else if (play_q != APCR_PL_IDLE && step_due) begin
         addr_q <= addr_q + 1'b1; // [R15] [R16]
      end
   end

   assign message_addr_o = addr_q;
   assign cueing_o = (play_q == APCR_PL_CUE);

endmodule : apcr_regs

// [test/apcr_properties.sv]
// Concurrent checks on the configuration register block ports
`timescale 1ns/100ps
module apcr_properties #(
   parameter int STEP_8K0 = 1024,
   parameter int STEP_6K4 = 1280,
   parameter int STEP_5K3 = 1536
) (
   input logic ref_clk_i,
   input logic sys_rst_i,
   input logic scl_i,
   input logic sda_i,
   input logic sda_o,
   input logic sda_oe_n_o,
   input logic playback_i,
   input logic cue_start_i,
   input logic message_end_marker_i,
   input apcr_pkg::apcr_first_cfg_t first_cfg_o,
   input apcr_pkg::apcr_second_cfg_t second_cfg_o,
   input apcr_pkg::apcr_path_ctrl_t path_ctrl_o,
   input logic [apcr_pkg::ADDR_W-1:0] message_addr_o,
   input logic cueing_o
);
   int cue_per;
   logic [15:0] gap_q;
   logic [apcr_pkg::ADDR_W-1:0] addr_q;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);

   // Cue step spacing follows the live rate code; reserved code runs as 8 kHz
   always_comb begin
      case (second_cfg_o.rate_select)
         2'h1: cue_per = STEP_6K4 / 512;
         2'h2: cue_per = STEP_5K3 / 512;
         default: cue_per = STEP_8K0 / 512;
      endcase
   end
   // Cycles without an address step while cueing; a playback-rate step would push it past cue_per
   always_ff @(posedge ref_clk_i) begin
      addr_q <= message_addr_o;
      gap_q <= (sys_rst_i || !cueing_o || message_addr_o != addr_q) ? 16'h0000 : gap_q + 16'h0001;
   end

   commit_on_scl_a: assert property (($changed(first_cfg_o) || $changed(second_cfg_o))
      |-> $past(scl_i) && $past(scl_i, 2)) else $error("register commit away from SCL high");
   mixer_dec_a: assert property (!$past(sys_rst_i) |->
      path_ctrl_o.first_mixer_from_line_in == ($past(second_cfg_o.first_mixer_select) == 2'h0)
      && path_ctrl_o.first_mixer_on == ($past(second_cfg_o.first_mixer_mode) != 2'h3))
      else $error("first mixer decode wrong");
   filter_dec_a: assert property (!$past(sys_rst_i) |->
      path_ctrl_o.filter_from_array == $past(second_cfg_o.filter_source_select)
      && path_ctrl_o.lowpass_on == !$past(second_cfg_o.lowpass_powerdown)
      && path_ctrl_o.second_mixer_filter_only == ($past(second_cfg_o.second_mixer_mode) == 2'h2))
      else $error("filter path decode wrong");
   rate_dec_a: assert property ($changed(second_cfg_o.rate_select)
      && second_cfg_o.rate_select != 2'h3 |=> path_ctrl_o.sample_rate ==
      $past(second_cfg_o.rate_select)) else $error("sample rate decode wrong");
   gain_amp_dec_a: assert property (!$past(sys_rst_i) |->
      path_ctrl_o.gain_amp_on == !$past(second_cfg_o.gain_amp_powerdown)
      && path_ctrl_o.input_from_gain_amp == !$past(first_cfg_o.input_source_select))
      else $error("gain amplifier decode wrong");
   volume_dec_a: assert property (!$past(sys_rst_i) |->
      path_ctrl_o.volume_from_second_mixer == ($past(second_cfg_o.volume_source_select) == 2'h1)
      && path_ctrl_o.volume_on == !$past(first_cfg_o.volume_powerdown)
      && path_ctrl_o.attenuation_code == $past(second_cfg_o.attenuation_code))
      else $error("volume decode wrong");
   output_dec_a: assert property (!$past(sys_rst_i) |->
      path_ctrl_o.output_from_volume == ($past(first_cfg_o.output_select) == 2'h0)
      && path_ctrl_o.speaker_high_gain == ($past(first_cfg_o.output_stage_mode) == 2'h1)
      && path_ctrl_o.line_out_on == !$past(first_cfg_o.line_out_powerdown))
      else $error("output stage decode wrong");
   gain_db_a: assert property (!$past(sys_rst_i) && $stable(first_cfg_o) [*2] |->
      path_ctrl_o.aux_gain_db == 4'h3 * {2'h0, first_cfg_o.aux_gain}
      && path_ctrl_o.line_in_gain_db == 4'h6 + 4'h3 * {2'h0, first_cfg_o.line_in_gain})
      else $error("input gain figure wrong");
   cue_pace_a: assert property (cueing_o |-> gap_q <= cue_per)
      else $error("cue step too slow");
   cue_stop_a: assert property ($fell(cueing_o) && $past(playback_i) && playback_i
      |-> $past(message_end_marker_i) || $past(message_end_marker_i, 2))
      else $error("cue ended without end marker");

   cover property ($fell(sda_oe_n_o));
   cover property ($changed(first_cfg_o));
   cover property ($fell(cueing_o) && playback_i);
endmodule : apcr_properties

bind apcr_regs apcr_properties #(.STEP_8K0(STEP_8K0), .STEP_6K4(STEP_6K4),
   .STEP_5K3(STEP_5K3)) i_props (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
   .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
   .playback_i(playback_i), .cue_start_i(cue_start_i),
   .message_end_marker_i(message_end_marker_i), .first_cfg_o(first_cfg_o),
   .second_cfg_o(second_cfg_o), .path_ctrl_o(path_ctrl_o),
   .message_addr_o(message_addr_o), .cueing_o(cueing_o));

// [test/apcr_host_model.sv]
// Serial bus host model that loads the configuration registers
`timescale 1ns/100ps
module apcr_host_model (
   output logic scl_o,
   output logic sda_o,
   input wire logic sda_i
);
   // Idle bus: both lines released to their pull-ups, clock stands still
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // One byte MSB first at 160 ns per bit, then a ninth clock that samples the acknowledge
   task automatic send(input logic [7:0] b, inout int acks);
      for (int i = 7; i >= 0; i--) begin
         #40 sda_o = b[i];
         #40 scl_o = 1'b1;
         #80 scl_o = 1'b0;
      end
      #40 sda_o = 1'b1;
      #40 scl_o = 1'b1;
      #40 acks += (sda_i === 1'b0) ? 1 : 0;
      #40 scl_o = 1'b0;
   endtask : send
   // Start, address, command, n data bytes from the top of d, stop
   task automatic frame(input logic [7:0] adr, input logic [7:0] cmd, input logic [31:0] d,
      input int n, output int acks);
      acks = 0;
      #40 sda_o = 1'b0;
      #80 scl_o = 1'b0;
      send(adr, acks);
      send(cmd, acks);
      for (int k = 0; k < n; k++) send(d[31-8*k -: 8], acks);
      #40 sda_o = 1'b0;
      #40 scl_o = 1'b1;
      #80 sda_o = 1'b1;
      #80;
   endtask : frame
   // The first register always travels with the second, and ahead of it
   task automatic write_both(input logic [15:0] w0, input logic [15:0] w1, output int acks);
      frame(apcr_pkg::SLAVE_ADDR_W, apcr_pkg::CMD_LOAD_BOTH, {w0, w1}, 4, acks);
   endtask : write_both
endmodule : apcr_host_model

// [test/audio_path_config_regs_tb_top.sv]
// Self-checking bench for the audio path configuration registers
`timescale 1ns/100ps
module audio_path_config_regs_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic play = 1'b0;
   logic cue = 1'b0;
   logic mark = 1'b0;
   logic scl, host_sda, sda_o, sda_oe_n, cueing;
   wire sda_w;
   apcr_pkg::apcr_first_cfg_t f;
   apcr_pkg::apcr_second_cfg_t s;
   apcr_pkg::apcr_path_ctrl_t p;
   logic [15:0] addr, a0;
   int mismatches = 0;
   int check_count = 0;
   int cycles = 0;
   int acks;

   always #5 clk = ~clk;
   // Open-drain data wire: low whenever either party pulls it
   assign sda_w = host_sda & (sda_oe_n | sda_o);

   apcr_host_model i_host (.scl_o(scl), .sda_o(host_sda), .sda_i(sda_w));
   // Short step counts keep playback and cueing runs brief
   apcr_regs #(.STEP_8K0(1024), .STEP_6K4(1280), .STEP_5K3(1536)) i_dut (
      .ref_clk_i(clk), .sys_rst_i(rst), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_n_o(sda_oe_n), .playback_i(play), .cue_start_i(cue),
      .message_end_marker_i(mark), .first_cfg_o(f), .second_cfg_o(s), .path_ctrl_o(p),
      .message_addr_o(addr), .cueing_o(cueing));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic cue_pulse();
      cue = 1'b1;
      cyc(1);
      cue = 1'b0;
   endtask : cue_pulse
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_of_test

   // Watchdog well above the few thousand cycles the sequence needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         mismatches++;
         end_of_test();
      end
   end

   initial begin
      cyc(5);
      rst = 1'b0;
      cyc(5);
      check(f, 16'h0000);
      check(s, 16'h0000);
      // Feed-through setup loads both registers
      i_host.write_both(16'h440B, 16'h01E3, acks);
      cyc(2);
      check(acks, 6);
      check(f, 16'h440B);
      check(s, 16'h01E3);
      check(p.output_from_line_in, 1'b1);
      check(p.speaker_high_gain, 1'b1);
      check(p.aux_out_on, 1'b0);
      check(p.volume_on, 1'b0);
      check(p.line_in_gain_db, 4'h9);
      check(p.line_out_from_mic, 1'b1);
      check(p.line_out_on, 1'b1);
      check(p.first_mixer_on, 1'b0);
      // Call record changes only the second register
      i_host.frame(8'h80, apcr_pkg::CMD_LOAD_SECOND, 32'h00C50000, 2, acks);
      cyc(2);
      check(acks, 4);
      check(f, 16'h440B);
      check(p.first_mixer_from_line_in, 1'b1);
      check(p.first_mixer_pass_select, 1'b1);
      check(p.filter_from_array, 1'b0);
      check(p.lowpass_on, 1'b1);
      check(p.sample_rate, apcr_pkg::APCR_RATE_6K4);
      check(p.second_mixer_filter_only, 1'b1);
      // Memo record
      i_host.write_both(16'h2421, 16'h0148, acks);
      cyc(2);
      check(p.gain_amp_on, 1'b1);
      check(p.input_from_gain_amp, 1'b1);
      check(p.first_mixer_pass_source, 1'b1);
      check(p.sample_rate, apcr_pkg::APCR_RATE_5K3);
      check(p.line_in_gain_db, 4'h6);
      check(p.aux_gain_db, 4'h0);
      // Playback with top auxiliary gain code
      i_host.write_both(16'h3C24, 16'h59D1, acks);
      cyc(2);
      check(p.volume_from_second_mixer, 1'b1);
      check(p.volume_on, 1'b1);
      check(p.attenuation_code, 3'h3);
      check(p.output_from_volume, 1'b1);
      check(p.filter_from_array, 1'b1);
      check(p.sample_rate, apcr_pkg::APCR_RATE_8K0);
      check(p.aux_gain_db, 4'h9);
      // Wrong address, unknown command, lone byte, first word alone: none commit
      i_host.frame(8'h82, apcr_pkg::CMD_LOAD_SECOND, 32'h12340000, 2, acks);
      check(acks, 0);
      i_host.frame(8'h80, 8'h8E, 32'h12340000, 2, acks);
      check(acks, 1);
      i_host.frame(8'h80, apcr_pkg::CMD_LOAD_SECOND, 32'h12340000, 1, acks);
      i_host.frame(8'h80, apcr_pkg::CMD_LOAD_BOTH, 32'hC0000000, 2, acks);
      cyc(2);
      check(f, 16'h3C24);
      check(s, 16'h59D1);
      // Cue request outside playback is ignored
      cue_pulse();
      cyc(3);
      check(cueing, 1'b0);
      // Cue onto a marker: one step, then stop at the next message
      play = 1'b1;
      mark = 1'b1;
      cyc(3);
      a0 = addr;
      cue_pulse();
      cyc(10);
      check(cueing, 1'b0);
      check(addr, a0 + 16'h0001);
      // Cue through unmarked messages far faster than playback steps
      mark = 1'b0;
      a0 = addr;
      cue_pulse();
      cyc(20);
      check(cueing, 1'b1);
      check(addr - a0 > 16'h0007, 1'b1);
      mark = 1'b1;
      cyc(8);
      check(cueing, 1'b0);
      play = 1'b0;
      cyc(5);
      end_of_test();
   end
endmodule : audio_path_config_regs_tb_top
